// file: logic/tcch_pkg.sv
// Constants for one timer channel register block
package tcch_pkg;
  localparam int unsigned CNT_W    = 16;
  localparam int unsigned EV_W     = 8;
  // Register byte offsets
  localparam logic [7:0] OFF_CV    = 8'h00;
  localparam logic [7:0] OFF_RA    = 8'h04;
  localparam logic [7:0] OFF_RB    = 8'h08;
  localparam logic [7:0] OFF_RC    = 8'h0c;
  localparam logic [7:0] OFF_SR    = 8'h10;
  localparam logic [7:0] OFF_IER   = 8'h14;
  localparam logic [7:0] OFF_IDR   = 8'h18;
  localparam logic [7:0] OFF_IMR   = 8'h1c;
  localparam logic [7:0] OFF_CTRL  = 8'h20;
  // Status bit positions
  localparam int unsigned SB_OVF   = 0;
  localparam int unsigned SB_LOVR  = 1;
  localparam int unsigned SB_MA    = 2;
  localparam int unsigned SB_MB    = 3;
  localparam int unsigned SB_MC    = 4;
  localparam int unsigned SB_LDA   = 5;
  localparam int unsigned SB_LDB   = 6;
  localparam int unsigned SB_ETRG  = 7;
  // Control bit positions
  localparam int unsigned CB_CLKEN = 0;
  localparam int unsigned CB_WAVE  = 1;
  localparam int unsigned CB_SWTRG = 2;
  localparam int unsigned CB_EVT   = 4;
  localparam int unsigned CB_SWACT = 6;
  // Flags that only exist in one mode
  localparam logic [7:0] WAVE_ONLY = 8'h0c;
  localparam logic [7:0] CAP_ONLY  = 8'h62;
  // Reset values
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [7:0] MASK_RST  = 8'h00;
  localparam logic [7:0] FLAG_RST  = 8'h00;
  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_SET  = 2'h1,
    ACT_CLR  = 2'h2,
    ACT_TGL  = 2'h3
  } tcch_act_type;
endpackage

// file: logic/tcch_flag_if.sv
// Event, clear and mask signals between channel core and status block
`timescale 1ns/1ps
`default_nettype none
interface tcch_flag_if;
  logic [7:0] setEv;
  logic [7:0] clrEv;
  logic [7:0] maskSet;
  logic [7:0] maskClr;
  logic       wave;
  logic [7:0] flags;
  logic [7:0] mask;
  logic       irq;
  modport core (output setEv, clrEv, maskSet, maskClr, wave, input flags, mask, irq);
  modport stat (input setEv, clrEv, maskSet, maskClr, wave, output flags, mask, irq);
endinterface
`default_nettype wire

// file: logic/tcch_sync.sv
// Three-flop input synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module tcch_sync #(
  parameter int unsigned W = 3
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Pins in, filtered level and edges out
  input  wire logic [W-1:0] async,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] s1_q, s2_q, s3_q;
  logic [W-1:0] level_d;

  // Stage one feeds only stage two
  always_ff @(posedge clk) begin
    s1_q <= async;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // A change counts once stages two and three agree
  assign level_d = (s2_q & ~(s2_q ^ s3_q)) | (level & (s2_q ^ s3_q));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level <= '0;
      rise  <= '0;
      fall  <= '0;
    end else begin
      level <= level_d;
      rise  <= level_d & ~level;
      fall  <= ~level_d & level;
    end
  end
endmodule
`default_nettype wire

// file: logic/tcch_status.sv
// Sticky event flags, interrupt mask and interrupt request
`timescale 1ns/1ps
`default_nettype none
module tcch_status (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Core side
  tcch_flag_if.stat fi
);
  logic [7:0] flags_q;
  logic [7:0] mask_q;
  logic       irq_q;
  logic [7:0] modeMask;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Mode-only flags read as zero in the other mode
  assign modeMask = fi.wave ? ~tcch_pkg::CAP_ONLY : ~tcch_pkg::WAVE_ONLY;
  assign fi.flags = flags_q & modeMask;
  assign fi.mask  = mask_q;
  assign fi.irq   = irq_q;

  // A new event beats the read that clears it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_q <= tcch_pkg::FLAG_RST;
    end else begin
      flags_q <= (flags_q & ~fi.clrEv) | fi.setEv;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_q <= tcch_pkg::MASK_RST;
    end else begin
      mask_q <= (mask_q | fi.maskSet) & ~fi.maskClr;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(fi.flags & mask_q);
    end
  end

  a_set_wins_clear: assert property (|fi.setEv
    |=> (flags_q & $past(fi.setEv)) == $past(fi.setEv))
    else $error("event lost against clear");
  a_mask_set_bits: assert property (|fi.maskSet |=> (mask_q & $past(fi.maskSet)) == $past(fi.maskSet))
    else $error("enable write did not set mask");
  a_mask_clr_bits: assert property (|fi.maskClr |=> (mask_q & $past(fi.maskClr)) == 8'h00)
    else $error("disable write did not clear mask");
  a_irq_follows: assert property (##1 irq_q == |($past(fi.flags) & $past(mask_q)))
    else $error("interrupt does not follow flags and mask");
endmodule
`default_nettype wire

// file: logic/tcch_top.sv
// Timer channel register block with APB slave, status flags and line B actions
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tcch_top #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Timer lines
  input  wire logic              ioLineAIn,
  output logic                   ioLineAOut,
  output logic                   ioLineAOe,
  input  wire logic              ioLineBIn,
  output logic                   ioLineBOut,
  output logic                   ioLineBOe,
  input  wire logic              extTrigIn,
  // Interrupt
  output logic                   irq
);
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_MAX = 16'hffff;

  logic [2:0]  pinLvl;
  logic [2:0]  pinRise;
  logic [2:0]  pinFall;
  logic [7:0]  addr;
  logic        setup;
  logic        access;
  logic        mapped;
  logic        wrEn;
  logic        rdEn;
  logic        swTrig;
  logic        clkEn_q;
  logic        wave_q;
  logic [1:0]  evtAct_q;
  logic [1:0]  swAct_q;
  logic [15:0] cnt_q;
  logic [15:0] cntNext;
  logic [15:0] ra_q;
  logic [15:0] rb_q;
  logic [15:0] rc_q;
  logic        aUnread_q;
  logic        bUnread_q;
  logic        lineA_q;
  logic        lineB_q;
  logic        lineB_d;
  logic        stepping;
  logic        ovfEv;
  logic        matchA;
  logic        matchB;
  logic        matchC;
  logic        loadA;
  logic        loadB;
  logic        overrun;
  logic        extEv;
  logic        mirA;
  logic        mirB;

  tcch_flag_if fi ();

  tcch_sync #(
    .W(3)
  ) uSync (
    .clk    (clk),
    .sys_rst(sys_rst),
    .async  ({extTrigIn, ioLineBIn, ioLineAIn}),
    .level  (pinLvl),
    .rise   (pinRise),
    .fall   (pinFall)
  );

  tcch_status uStat (
    .clk    (clk),
    .sys_rst(sys_rst),
    .fi     (fi.stat)
  );

  function automatic logic applyAct(input logic [1:0] act, input logic lvl);
    unique case (tcch_pkg::tcch_act_type'(act))
      tcch_pkg::ACT_NONE: applyAct = lvl;
      tcch_pkg::ACT_SET:  applyAct = 1'b1;
      tcch_pkg::ACT_CLR:  applyAct = 1'b0;
      tcch_pkg::ACT_TGL:  applyAct = ~lvl;
    endcase
  endfunction

  // APB decode; always ready, so every access lasts one cycle
  assign addr   = paddr[7:0];
  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign pready = 1'b1;

  always_comb begin
    mapped = 1'b0;
    if (ADDR_W == 8 || paddr == ADDR_W'(addr)) begin
      unique case (addr)
        tcch_pkg::OFF_CV,
        tcch_pkg::OFF_RA,
        tcch_pkg::OFF_RB,
        tcch_pkg::OFF_RC,
        tcch_pkg::OFF_SR,
        tcch_pkg::OFF_IER,
        tcch_pkg::OFF_IDR,
        tcch_pkg::OFF_IMR,
        tcch_pkg::OFF_CTRL: mapped = 1'b1;
        default:            mapped = 1'b0;
      endcase
    end
  end

  assign pslverr = access & ~mapped;
  assign wrEn    = access & pwrite & mapped;
  assign rdEn    = access & ~pwrite & mapped;
  assign swTrig  = wrEn && addr == tcch_pkg::OFF_CTRL && pwdata[tcch_pkg::CB_SWTRG];

  // Control register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wave_q   <= 1'b0;
      evtAct_q <= 2'h0;
      swAct_q  <= 2'h0;
    end else if (wrEn && addr == tcch_pkg::OFF_CTRL) begin
      wave_q   <= pwdata[tcch_pkg::CB_WAVE];
      evtAct_q <= pwdata[tcch_pkg::CB_EVT +: 2];
      swAct_q  <= pwdata[tcch_pkg::CB_SWACT +: 2];
    end
  end

  // Software trigger also starts the counter clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clkEn_q <= 1'b0;
    end else if (wrEn && addr == tcch_pkg::OFF_CTRL) begin
      clkEn_q <= pwdata[tcch_pkg::CB_CLKEN] | pwdata[tcch_pkg::CB_SWTRG];
    end
  end

  // Counter
  assign cntNext  = cnt_q + CNT_ONE;
  assign stepping = clkEn_q & ~swTrig;

  always_ff @(posedge clk) begin
    if (sys_rst || swTrig) begin
      cnt_q <= tcch_pkg::CNT_RST;
    end else if (clkEn_q) begin
      cnt_q <= cntNext;
    end
  end

  // Events
  assign ovfEv   = stepping && cnt_q == CNT_MAX;
  assign matchA  = stepping && wave_q && cntNext == ra_q;
  assign matchB  = stepping && wave_q && cntNext == rb_q;
  assign matchC  = stepping && cntNext == rc_q;
  assign loadA   = ~wave_q & pinRise[0];
  assign loadB   = ~wave_q & pinFall[0];
  assign overrun = (loadA & aUnread_q) | (loadB & bUnread_q);
  assign extEv   = pinRise[2];

  // Register A: hardware load in capture, software write in waveform
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ra_q <= tcch_pkg::CNT_RST;
    end else if (loadA) begin
      ra_q <= cnt_q;
    end else if (wrEn && wave_q && addr == tcch_pkg::OFF_RA) begin
      ra_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rb_q <= tcch_pkg::CNT_RST;
    end else if (loadB) begin
      rb_q <= cnt_q;
    end else if (wrEn && wave_q && addr == tcch_pkg::OFF_RB) begin
      rb_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rc_q <= tcch_pkg::CNT_RST;
    end else if (wrEn && addr == tcch_pkg::OFF_RC) begin
      rc_q <= pwdata[15:0];
    end
  end

  // Loaded-but-unread tracking; a load in the reading cycle stays unread
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aUnread_q <= 1'b0;
      bUnread_q <= 1'b0;
    end else begin
      aUnread_q <= loadA | (aUnread_q & ~(rdEn && addr == tcch_pkg::OFF_RA));
      bUnread_q <= loadB | (bUnread_q & ~(rdEn && addr == tcch_pkg::OFF_RB));
    end
  end

  // Line drive; software trigger action is applied on top of a coincident event action
  always_comb begin
    lineB_d = lineB_q;
    if (extEv) begin
      lineB_d = applyAct(evtAct_q, lineB_d);
    end
    if (swTrig) begin
      lineB_d = applyAct(pwdata[tcch_pkg::CB_SWACT +: 2], lineB_d);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lineB_q <= 1'b0;
    end else if (wave_q) begin
      lineB_q <= lineB_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lineA_q <= 1'b0;
    end else if (matchA) begin
      lineA_q <= 1'b1;
    end else if (wave_q && matchC) begin
      lineA_q <= 1'b0;
    end
  end

  assign ioLineAOut = lineA_q;
  assign ioLineBOut = lineB_q;
  assign ioLineAOe  = wave_q;
  assign ioLineBOe  = wave_q;
  assign irq        = fi.irq;

  assign mirA = wave_q ? lineA_q : pinLvl[0];
  assign mirB = wave_q ? lineB_q : pinLvl[1];

  // Status block hookup; read clears only flags already returned
  assign fi.wave    = wave_q;
  assign fi.setEv   = {extEv, loadB, loadA, matchC, matchB, matchA, overrun, ovfEv};
  assign fi.clrEv   = (rdEn && addr == tcch_pkg::OFF_SR) ? prdata[7:0] : 8'h00;
  assign fi.maskSet = (wrEn && addr == tcch_pkg::OFF_IER) ? pwdata[7:0] : 8'h00;
  assign fi.maskClr = (wrEn && addr == tcch_pkg::OFF_IDR) ? pwdata[7:0] : 8'h00;

  // Read data sampled in the setup cycle, held through the access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= 32'h0000_0000;
      unique case (addr)
        tcch_pkg::OFF_CV:   prdata <= {16'h0000, cnt_q};
        tcch_pkg::OFF_RA:   prdata <= {16'h0000, ra_q};
        tcch_pkg::OFF_RB:   prdata <= {16'h0000, rb_q};
        tcch_pkg::OFF_RC:   prdata <= {16'h0000, rc_q};
        tcch_pkg::OFF_SR:   prdata <= {13'h0000, mirB, mirA, clkEn_q, 8'h00, fi.flags};
        tcch_pkg::OFF_IMR:  prdata <= {24'h000000, fi.mask};
        tcch_pkg::OFF_CTRL: prdata <= {24'h000000, swAct_q, evtAct_q, 2'h0, wave_q, clkEn_q};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_overflow_flag: assert property (ovfEv |=> fi.flags[tcch_pkg::SB_OVF] && cnt_q == 16'h0000)
    else $error("overflow not flagged");
  a_ra_capture_ro: assert property (wrEn && addr == tcch_pkg::OFF_RA && !wave_q && !loadA
    |=> ra_q == $past(ra_q))
    else $error("register A written in capture mode");
  a_sw_trig_line: assert property (swTrig && wave_q && pwdata[7:6] == 2'h1 |=> lineB_q && cnt_q == 16'h0000)
    else $error("software trigger did not set line B");
  a_sw_trig_clear: assert property (swTrig && wave_q && pwdata[7:6] == 2'h2 |=> !lineB_q)
    else $error("software trigger did not clear line B");
  a_event_toggle: assert property (extEv && !swTrig && wave_q && evtAct_q == 2'h3
    |=> lineB_q != $past(lineB_q))
    else $error("external event did not toggle line B");
  a_overrun_cap: assert property (loadA && aUnread_q |=> fi.flags[tcch_pkg::SB_LOVR] || wave_q)
    else $error("overrun not flagged");
  a_mirror_pin: assert property (setup && addr == tcch_pkg::OFF_SR && !wave_q
    |=> prdata[18:17] == $past(pinLvl[1:0]))
    else $error("mirror does not follow pins");
  a_unmapped_err: assert property (access && !mapped |-> pslverr && pready)
    else $error("unmapped access not refused");

  // Register access
  a_rb_capture_ro: assert property (wrEn && addr == tcch_pkg::OFF_RB && !wave_q && !loadB
    |=> rb_q == $past(rb_q))
    else $error("register B written in capture mode");
  a_ra_wave_wr: assert property (wrEn && addr == tcch_pkg::OFF_RA && wave_q
    |=> ra_q == $past(pwdata[15:0]))
    else $error("register A write lost in waveform mode");
  a_rb_wave_wr: assert property (wrEn && addr == tcch_pkg::OFF_RB && wave_q
    |=> rb_q == $past(pwdata[15:0]))
    else $error("register B write lost in waveform mode");
  a_rc_write_any: assert property (wrEn && addr == tcch_pkg::OFF_RC
    |=> rc_q == $past(pwdata[15:0]))
    else $error("register C write lost");
  a_cv_read_live: assert property (setup && addr == tcch_pkg::OFF_CV
    |=> prdata == {16'h0000, $past(cnt_q)})
    else $error("counter read data wrong");
  a_cnt_step: assert property (clkEn_q && !swTrig
    |=> cnt_q == $past(cnt_q) + CNT_ONE)
    else $error("counter did not step");
  a_sw_trig_restart: assert property (swTrig |=> cnt_q == 16'h0000 && clkEn_q)
    else $error("software trigger did not restart counter");
  a_clk_status_rd: assert property (setup && addr == tcch_pkg::OFF_SR
    |=> prdata[16] == $past(clkEn_q))
    else $error("clock indicator read wrong");
  a_mask_read: assert property (setup && addr == tcch_pkg::OFF_IMR
    |=> prdata == {24'h000000, $past(fi.mask)})
    else $error("mask read wrong");

  // Flags and line actions
  a_event_set: assert property (extEv && !swTrig && wave_q && evtAct_q == 2'h1
    |=> lineB_q)
    else $error("external event did not set line B");
  a_match_a_flag: assert property (matchA |=> fi.flags[tcch_pkg::SB_MA] || !wave_q)
    else $error("match A not flagged");
  a_match_b_flag: assert property (matchB |=> fi.flags[tcch_pkg::SB_MB] || !wave_q)
    else $error("match B not flagged");
  a_match_c_flag: assert property (matchC |=> fi.flags[tcch_pkg::SB_MC])
    else $error("match C not flagged");
  a_load_a_flag: assert property (loadA |=> fi.flags[tcch_pkg::SB_LDA] || wave_q)
    else $error("load A not flagged");
  a_load_b_flag: assert property (loadB |=> fi.flags[tcch_pkg::SB_LDB] || wave_q)
    else $error("load B not flagged");
  a_overrun_b: assert property (loadB && bUnread_q |=> fi.flags[tcch_pkg::SB_LOVR] || wave_q)
    else $error("register B overrun not flagged");
  a_ext_trig_flag: assert property (extEv |=> fi.flags[tcch_pkg::SB_ETRG])
    else $error("external trigger not flagged");
  a_wave_only_zero: assert property (!wave_q |-> (fi.flags & tcch_pkg::WAVE_ONLY) == 8'h00)
    else $error("match flag visible in capture mode");
  a_cap_only_zero: assert property (wave_q |-> (fi.flags & tcch_pkg::CAP_ONLY) == 8'h00)
    else $error("capture flag visible in waveform mode");
  a_sr_read_clears: assert property (rdEn && addr == tcch_pkg::OFF_SR
    && prdata[0] && !ovfEv |=> !fi.flags[tcch_pkg::SB_OVF])
    else $error("status read did not clear overflow");
endmodule
`default_nettype wire

// file: tb/tcch_line_model.sv
// Far-side model of the two timer lines and the trigger pin
`timescale 1ns/1ps
`default_nettype none
module tcch_line_model (
  // Channel drive
  input  wire logic aOut,
  input  wire logic aOe,
  input  wire logic bOut,
  input  wire logic bOe,
  // Levels the far side puts on the wires
  input  wire logic aLevel,
  input  wire logic bLevel,
  input  wire logic trigLevel,
  // Resolved pins
  output logic      aPin,
  output logic      bPin,
  output logic      trigPin
);
  // Far side drives only while the channel has released the line
  assign aPin    = aOe ? aOut : aLevel;
  assign bPin    = bOe ? bOut : bLevel;
  assign trigPin = trigLevel;
endmodule
`default_nettype wire

// file: tb/tcch_top_test.sv
// Self-checking bench for the timer channel register block
`timescale 1ns/1ps
`default_nettype none
module tcch_top_test;
  logic        clk, sysRst, psel, penable, pwrite, pready, pslverr, errSeen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, ra;
  logic        aOut, aOe, bOut, bOe, aPin, bPin, trigPin, irq, lineB;
  logic        aLevel, bLevel, trigLevel;
  int          miscompares, totalChecks, cycles;

  tcch_top uut (.clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ioLineAIn(aPin), .ioLineAOut(aOut), .ioLineAOe(aOe),
    .ioLineBIn(bPin), .ioLineBOut(bOut), .ioLineBOe(bOe), .extTrigIn(trigPin), .irq(irq));
  tcch_line_model lines (.aOut(aOut), .aOe(aOe), .bOut(bOut), .bOe(bOe), .aLevel(aLevel),
    .bLevel(bLevel), .trigLevel(trigLevel), .aPin(aPin), .bPin(bPin), .trigPin(trigPin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Whole run is dominated by one counter wrap of 65536 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd      = prdata;
    errSeen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdChk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask

  task automatic pulseA;
    aLevel <= 1'b1;
    waitc(8);
    aLevel <= 1'b0;
    waitc(8);
  endtask

  task automatic trig;
    trigLevel <= 1'b1;
    waitc(2);
    trigLevel <= 1'b0;
    waitc(8);
  endtask

  function automatic logic nextB(input logic cur, input logic [1:0] act);
    case (act)
      2'h1: return 1'b1;
      2'h2: return 1'b0;
      2'h3: return ~cur;
      default: return cur;
    endcase
  endfunction

  initial begin
    sysRst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    aLevel = 1'b0;
    bLevel = 1'b0;
    trigLevel = 1'b0;
    miscompares = 0;
    totalChecks = 0;
    cycles = 0;
    lineB = 1'b0;
    waitc(2);
    sysRst <= 1'b0;
    rdChk("cv reset", tcch_pkg::OFF_CV, 32'h0);
    rdChk("sr reset", tcch_pkg::OFF_SR, 32'h0);
    check("oe capture", {30'h0, aOe, bOe}, 32'h0);
    rdChk("imr reset", tcch_pkg::OFF_IMR, 32'h0);
    rdChk("unmapped", 8'h24, 32'h0);
    check("unmapped err", {31'h0, errSeen}, 32'h1);
    wr(tcch_pkg::OFF_RC, 32'hffffbeef);
    rdChk("rc capture", tcch_pkg::OFF_RC, 32'h0000beef);
    wr(tcch_pkg::OFF_RA, 32'h1234);
    rdChk("ra ignored", tcch_pkg::OFF_RA, 32'h0);
    wr(tcch_pkg::OFF_RB, 32'h5678);
    rdChk("rb ignored", tcch_pkg::OFF_RB, 32'h0);
    wr(tcch_pkg::OFF_IER, 32'hffffffa5);
    rdChk("imr a", tcch_pkg::OFF_IMR, 32'ha5);
    wr(tcch_pkg::OFF_IER, 32'h0a);
    rdChk("imr b", tcch_pkg::OFF_IMR, 32'haf);
    wr(tcch_pkg::OFF_IDR, 32'h21);
    rdChk("imr c", tcch_pkg::OFF_IMR, 32'h8e);
    wr(tcch_pkg::OFF_IDR, 32'h0);
    rdChk("imr d", tcch_pkg::OFF_IMR, 32'h8e);
    trig();
    check("irq trig", {31'h0, irq}, 32'h1);
    rdChk("sr trig", tcch_pkg::OFF_SR, 32'h80);
    rdChk("sr cleared", tcch_pkg::OFF_SR, 32'h0);
    waitc(2);
    check("irq clear", {31'h0, irq}, 32'h0);
    // Capture mode with the counter running
    wr(tcch_pkg::OFF_CTRL, 32'h1);
    bLevel <= 1'b1;
    waitc(8);
    rdChk("sr clk on", tcch_pkg::OFF_SR, 32'h50000);
    pulseA();
    rdChk("sr loads", tcch_pkg::OFF_SR, 32'h50060);
    pulseA();
    rdChk("sr overrun", tcch_pkg::OFF_SR, 32'h50062);
    apb(1'b0, tcch_pkg::OFF_RA, 32'h0);
    ra = rd;
    apb(1'b0, tcch_pkg::OFF_RB, 32'h0);
    check("a before b", {31'h0, ra[15:0] < rd[15:0]}, 32'h1);
    pulseA();
    rdChk("sr no overrun", tcch_pkg::OFF_SR, 32'h50060);
    aLevel <= 1'b1;
    waitc(8);
    rdChk("sr mirror a", tcch_pkg::OFF_SR, 32'h70022);
    aLevel <= 1'b0;
    waitc(8);
    rdChk("sr b overrun", tcch_pkg::OFF_SR, 32'h50042);
    apb(1'b0, tcch_pkg::OFF_CV, 32'h0);
    ra = rd;
    apb(1'b0, tcch_pkg::OFF_CV, 32'h0);
    check("cv upper", {16'h0, rd[31:16]}, 32'h0);
    check("cv moving", {31'h0, rd !== ra}, 32'h1);
    wr(tcch_pkg::OFF_CTRL, 32'h0);
    apb(1'b0, tcch_pkg::OFF_CV, 32'h0);
    ra = rd;
    waitc(4);
    rdChk("cv held", tcch_pkg::OFF_CV, ra);
    rdChk("sr clk off", tcch_pkg::OFF_SR, 32'h40000);
    // Waveform mode
    wr(tcch_pkg::OFF_CTRL, 32'h3);
    wr(tcch_pkg::OFF_RA, 32'hffff0010);
    rdChk("ra wave", tcch_pkg::OFF_RA, 32'h10);
    wr(tcch_pkg::OFF_RB, 32'h20);
    rdChk("rb wave", tcch_pkg::OFF_RB, 32'h20);
    wr(tcch_pkg::OFF_RC, 32'h30);
    for (int i = 1; i <= 4; i++) begin
      wr(tcch_pkg::OFF_CTRL, 32'h7 | (32'(i[1:0]) << 6));
      waitc(3);
      lineB = nextB(lineB, i[1:0]);
      check("soft action", {31'h0, bOut}, {31'h0, lineB});
    end
    for (int i = 0; i < 4; i++) begin
      wr(tcch_pkg::OFF_CTRL, 32'h3 | (32'(2'(i * 3 + 2)) << 4));
      trig();
      lineB = nextB(lineB, 2'(i * 3 + 2));
      check("event action", {31'h0, bOut}, {31'h0, lineB});
    end
    // Counter restarts from zero, then passes A, B and C
    wr(tcch_pkg::OFF_CTRL, 32'h7);
    apb(1'b0, tcch_pkg::OFF_SR, 32'h0);
    waitc(20);
    check("line a set", {30'h0, aOe, aOut}, 32'h3);
    waitc(44);
    check("irq match", {31'h0, irq}, 32'h1);
    rdChk("sr match", tcch_pkg::OFF_SR, 32'h1001c | (32'(lineB) << 18));
    waitc(65536);
    rdChk("sr wrap", tcch_pkg::OFF_SR, 32'h1001d | (32'(lineB) << 18));
    print_verdict();
  end
endmodule
`default_nettype wire
